// ===== fics_fast_interrupt.sv
// Fast interrupt context swap: mode register, vector pointer, shadow
// flags and the entry/return sequencer. Assumes the CPU sequencer
// gives one-cycle strobes on the same clock and owns the PC and flags.
// Operation
// - Fast entry completes in six cycles; normal vectored entry takes sixteen.
// - Mode register bits 4..2 select the single fast interrupt level.
// - Mode register bit 1 alone turns the fast path on or off.
// - Any of the eight levels, zero to seven, may be selected.
// - Fast entry swaps the program counter with the vector pointer.
// - Fast entry copies live flags into an unmapped shadow register.
// - Fast entry sets the fast status bit in the shadow copy.
// - Return with fast status set swaps vector pointer and PC back.
// - Fast return restores live flags from the shadow register.
// - Fast return clears the fast status bit in live flags.
// - Fast path works for hardware- and software-cleared pending bits.
// - Global enable and disable gate all servicing, fast path included; the block gates only irqGrant, and an irqAck still starts entry.
// - Vector pointer is a 16-bit pair at indices DAH and DBH.
// - Fast status indication sits in flags bit 1.
// - Interrupt return sets global enable bit 0 of the mode register.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fics_fast_interrupt
    import fics_pkg::*;
#(
    parameter int FAST_CYCLES = FAST_ENTRY_CYCLES,
    parameter int NORMAL_CYCLES = NORMAL_ENTRY_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [fics_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [fics_pkg::DATA_W-1:0] writedata,
    output logic [fics_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // Interrupt request side
    input wire logic irqPending,
    output logic irqGrant,
    // CPU datapath side
    input wire fics_pkg::fics_cpu_in_t cpuIn,
    output fics_pkg::fics_cpu_out_t cpuOut
);
    import fics_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hitIdx(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
        hitIdx = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
    endfunction

    logic [7:0] sysMode_q;
    logic [15:0] vectorPtr_q;
    logic [7:0] shadowFlags_q;
    fics_state_t state_q;
    logic [CNT_W-1:0] count_q;
    logic readPhase_q;
    logic [DATA_W-1:0] readdata_q;
    fics_cpu_out_t out_q;

    logic wrMode;
    logic wrVpHigh;
    logic wrVpLow;
    logic fastMatch;
    logic fastEntry;
    logic normalEntry;
    logic fastReturn;
    logic globalEnable;
    logic [2:0] fastLevel;

    assign wrMode = write && hitIdx(address, SYS_MODE_IDX);
    assign wrVpHigh = write && hitIdx(address, VP_HIGH_IDX);
    assign wrVpLow = write && hitIdx(address, VP_LOW_IDX);
    assign globalEnable = sysMode_q[MODE_GIE_BIT];
    assign fastLevel = sysMode_q[MODE_LEVEL_LSB +: MODE_LEVEL_W];

    // ------------------------------------------------------------
    // Entry decision
    // ------------------------------------------------------------
    // global gate
    assign irqGrant = irqPending && globalEnable && (state_q == FICS_IDLE);
    assign fastMatch = sysMode_q[MODE_FAST_EN_BIT]
                       && (cpuIn.irqLevel == fastLevel);
    assign fastEntry = cpuIn.irqAck && (state_q == FICS_IDLE) && fastMatch;
    assign normalEntry = cpuIn.irqAck && (state_q == FICS_IDLE)
                         && !fastMatch;
    // return keyed on live status bit
    assign fastReturn = cpuIn.returnExec && cpuIn.flags[FLAG_FAST_BIT];

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // Hardware events come last so they win over a bus write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sysMode_q <= MODE_RESET;
        end else begin
            if (wrMode) begin
                sysMode_q <= writedata[7:0];
            end
            if (cpuIn.enableExec) begin
                sysMode_q[MODE_GIE_BIT] <= 1'b1;
            end
            if (cpuIn.disableExec) begin
                sysMode_q[MODE_GIE_BIT] <= 1'b0;
            end
            if (cpuIn.irqAck) begin
                sysMode_q[MODE_GIE_BIT] <= 1'b0;
            end
            if (cpuIn.returnExec) begin
                sysMode_q[MODE_GIE_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Vector pointer pair
    // ------------------------------------------------------------
    // two byte halves
    // swap on fast entry
    // Swap wins; a bus write in the same cycle is lost
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            vectorPtr_q <= VP_RESET;
        end else if (fastEntry || fastReturn) begin
            vectorPtr_q <= cpuIn.pc;
        end else begin
            if (wrVpHigh) begin
                vectorPtr_q[15:8] <= writedata[7:0];
            end
            if (wrVpLow) begin
                vectorPtr_q[7:0] <= writedata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Shadow flags
    // ------------------------------------------------------------
    // unmapped copy
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shadowFlags_q <= FLAGS_RESET;
        end else if (fastEntry) begin
            shadowFlags_q <= cpuIn.flags | FAST_MASK;
        end
    end

    // ------------------------------------------------------------
    // Entry sequencer
    // ------------------------------------------------------------
    // entry cycle counts
    // Count loads N-1 so busy stands exactly N cycles
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= FICS_IDLE;
            count_q <= '0;
        end else begin
            case (state_q)
                FICS_IDLE: begin
                    if (fastEntry) begin
                        state_q <= FICS_FAST;
                        count_q <= CNT_W'(FAST_CYCLES - 1);
                    end else if (normalEntry) begin
                        state_q <= FICS_NORMAL;
                        count_q <= CNT_W'(NORMAL_CYCLES - 1);
                    end
                end
                FICS_FAST, FICS_NORMAL: begin
                    if (count_q == '0) begin
                        state_q <= FICS_IDLE;
                    end else begin
                        count_q <= count_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= FICS_IDLE;
                    count_q <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // CPU datapath outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= '0;
        end else begin
            out_q.pcLoad <= fastEntry || fastReturn;
            if (fastEntry || fastReturn) begin
                out_q.pcValue <= vectorPtr_q;
            end
            out_q.flagsLoad <= fastReturn;
            if (fastReturn) begin
                out_q.flagsValue <= shadowFlags_q & ~FAST_MASK;
            end
            out_q.stackEntry <= normalEntry;
            out_q.entryBusy <= fastEntry || normalEntry
                               || ((state_q != FICS_IDLE)
                                   && (count_q != '0));
            out_q.entryDone <= (state_q != FICS_IDLE) && (count_q == '0);
            // same clear strobe both pending types
            out_q.pendingClear <= cpuIn.irqAck;
        end
    end
    assign cpuOut = out_q;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Reads wait one cycle so read data comes from a flip-flop
    // Writes never wait; unmapped reads return zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readPhase_q <= 1'b0;
            readdata_q <= '0;
        end else begin
            readPhase_q <= read && !readPhase_q;
            if (read && !readPhase_q) begin
                if (hitIdx(address, SYS_MODE_IDX)) begin
                    readdata_q <= {24'h00_0000, sysMode_q};
                end else if (hitIdx(address, VP_HIGH_IDX)) begin
                    readdata_q <= {24'h00_0000, vectorPtr_q[15:8]};
                end else if (hitIdx(address, VP_LOW_IDX)) begin
                    readdata_q <= {24'h00_0000, vectorPtr_q[7:0]};
                end else if (hitIdx(address, FLAGS_IDX)) begin
                    readdata_q <= {24'h00_0000, cpuIn.flags};
                end else begin
                    readdata_q <= '0;
                end
            end
        end
    end
    assign readdata = readdata_q;
    assign waitrequest = read && !readPhase_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // Cycle counts below assume the default parameters

    a_fast_entry_len: assert property (
        fastEntry |=> out_q.entryBusy [*6] ##1 !out_q.entryBusy
    ) else $error("fast entry length wrong");

    a_normal_entry_len: assert property (
        normalEntry |-> ##17 out_q.entryDone
    ) else $error("normal entry length wrong");

    a_fast_done: assert property (
        fastEntry |-> ##7 out_q.entryDone
    ) else $error("fast entry done late");

    a_level_select: assert property (
        fastEntry |-> cpuIn.irqLevel == sysMode_q[4:2]
    ) else $error("fast entry on wrong level");

    a_fast_enable_off: assert property (
        !sysMode_q[1] |-> !fastEntry
    ) else $error("fast entry while disabled");

    a_pc_swap_in: assert property (
        fastEntry |=> out_q.pcLoad && out_q.pcValue == $past(vectorPtr_q)
                      && vectorPtr_q == $past(cpuIn.pc)
    ) else $error("entry swap wrong");

    a_shadow_copy: assert property (
        fastEntry |=> shadowFlags_q == ($past(cpuIn.flags) | 8'h02)
    ) else $error("shadow copy wrong");

    a_shadow_status: assert property (
        fastEntry |=> shadowFlags_q[1]
    ) else $error("shadow status bit not set");

    a_return_swap: assert property (
        cpuIn.returnExec && cpuIn.flags[1] |=> out_q.pcLoad
                                             && vectorPtr_q == $past(cpuIn.pc)
    ) else $error("return swap missing");

    a_plain_return: assert property (
        cpuIn.returnExec && !cpuIn.flags[1] |=> !out_q.flagsLoad
    ) else $error("plain return restored flags");

    a_pending_clear: assert property (
        cpuIn.irqAck |=> out_q.pendingClear
    ) else $error("pending clear missing");

    a_global_clear: assert property (
        cpuIn.disableExec && !cpuIn.returnExec |=> !sysMode_q[0]
    ) else $error("disable left interrupts on");

    a_pointer_hold: assert property (
        !(fastEntry || fastReturn || wrVpHigh || wrVpLow)
            |=> $stable(vectorPtr_q)
    ) else $error("vector pointer changed");

    a_flags_restore: assert property (
        fastReturn |=> out_q.flagsLoad
                       && out_q.flagsValue[7:2] == $past(shadowFlags_q[7:2])
    ) else $error("flags not restored");

    a_status_clear: assert property (
        out_q.flagsLoad |-> !out_q.flagsValue[1]
    ) else $error("status bit not cleared");

    a_global_gate: assert property (
        !sysMode_q[0] |-> !irqGrant
    ) else $error("grant while globally disabled");

    a_return_enable: assert property (
        cpuIn.returnExec |=> sysMode_q[0]
    ) else $error("return left interrupts disabled");

    a_normal_fallback: assert property (
        normalEntry |=> out_q.stackEntry && !out_q.pcLoad
    ) else $error("normal entry not stacked");

    c_fast_entry: cover property (fastEntry);
    c_normal_entry: cover property (normalEntry);
    c_fast_return: cover property (fastReturn ##1 out_q.flagsLoad);
    c_plain_return: cover property (cpuIn.returnExec && !cpuIn.flags[1]);

endmodule
`default_nettype wire

// ===== fics_pkg.sv
// Package for the fast interrupt context swap block.
// Assumes a 100 MHz CPU clock and a 32-bit Avalon-MM register bus.
package fics_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] VP_HIGH_IDX = 8'hDA;
    localparam logic [7:0] VP_LOW_IDX = 8'hDB;
    localparam logic [7:0] SYS_MODE_IDX = 8'hDE;
    localparam logic [7:0] FLAGS_IDX = 8'hD5;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_GIE_BIT = 0;
    localparam int MODE_FAST_EN_BIT = 1;
    localparam int MODE_LEVEL_LSB = 2;
    localparam int MODE_LEVEL_W = 3;
    localparam int FLAG_FAST_BIT = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] VP_RESET = 16'h0000;
    localparam logic [7:0] FAST_MASK = 8'h02;

    // ------------------------------------------------------------
    // Entry timing in clock cycles
    // ------------------------------------------------------------
    localparam int FAST_ENTRY_CYCLES = 6;
    localparam int NORMAL_ENTRY_CYCLES = 16;
    localparam int CNT_W = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FICS_IDLE = 2'b00,
        FICS_FAST = 2'b01,
        FICS_NORMAL = 2'b10
    } fics_state_t;

    typedef struct packed {
        logic irqAck;
        logic [2:0] irqLevel;
        logic returnExec;
        logic enableExec;
        logic disableExec;
        logic [15:0] pc;
        logic [7:0] flags;
    } fics_cpu_in_t;

    typedef struct packed {
        logic pcLoad;
        logic [15:0] pcValue;
        logic flagsLoad;
        logic [7:0] flagsValue;
        logic stackEntry;
        logic entryBusy;
        logic entryDone;
        logic pendingClear;
    } fics_cpu_out_t;

endpackage

// ===== fics_cpu_model.sv
// CPU sequencer model: holds PC and live flags and obeys the block's loads.
// Assumes the bench drives each strobe for one cycle after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module fics_cpu_model
    import fics_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench requests: ack, return, enable, disable
    input wire logic [3:0] strobe,
    input wire logic [2:0] level,
    input wire logic setReq,
    input wire logic [23:0] setValue,
    // Block side
    input wire fics_pkg::fics_cpu_out_t cpuOut,
    output var fics_pkg::fics_cpu_in_t cpuIn,
    // Observed since the last ack
    output logic [7:0] busyCnt,
    output logic [2:0] seen
);
    import fics_pkg::*;

    logic [15:0] pc_q;
    logic [7:0] flags_q;

    always_comb begin
        cpuIn = '{strobe[0], level, strobe[1], strobe[2], strobe[3], pc_q,
                  flags_q};
    end

    // --------
    // PC and flags
    // --------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pc_q <= 16'h0000;
            flags_q <= 8'h00;
        end else if (setReq) begin
            {pc_q, flags_q} <= setValue;
        end else begin
            if (cpuOut.pcLoad) begin
                pc_q <= cpuOut.pcValue;
            end
            if (cpuOut.flagsLoad) begin
                flags_q <= cpuOut.flagsValue;
            end else if (cpuOut.pcLoad && cpuOut.entryBusy) begin
                flags_q[FLAG_FAST_BIT] <= 1'b1;
            end
        end
    end

    // --------
    // Entry observation
    // --------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt <= 8'h00;
            seen <= 3'b000;
        end else if (strobe[0]) begin
            busyCnt <= 8'h00;
            seen <= 3'b000;
        end else begin
            busyCnt <= busyCnt + 8'(cpuOut.entryBusy);
            seen <= seen | {cpuOut.stackEntry, cpuOut.pendingClear,
                            cpuOut.entryDone};
        end
    end
endmodule
`default_nettype wire

// ===== fics_fast_interrupt_tb.sv
// Self-checking bench for the fast interrupt context swap block.
// Assumes the package and the CPU model are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module fics_fast_interrupt_tb;
    import fics_pkg::*;
    localparam int FAST_N = 6;
    localparam int NORMAL_N = 16;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic irqPending = 1'b0;
    logic irqGrant;
    logic [3:0] strobe = 4'h0;
    logic [2:0] level = 3'h0;
    logic setReq = 1'b0;
    logic [23:0] setValue = 24'h00_0000;
    fics_cpu_in_t cpuIn;
    fics_cpu_out_t cpuOut;
    logic [7:0] busyCnt;
    logic [2:0] seen;
    int errCount = 0;
    int nTests = 0;

    fics_fast_interrupt #(.FAST_CYCLES(FAST_N), .NORMAL_CYCLES(NORMAL_N))
        fics_fast_interrupt_i (.clock(clock), .reset_n(reset_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irqPending(irqPending),
        .irqGrant(irqGrant), .cpuIn(cpuIn), .cpuOut(cpuOut));
    fics_cpu_model fics_cpu_model_i (.clock(clock), .reset_n(reset_n),
        .strobe(strobe), .level(level), .setReq(setReq),
        .setValue(setValue), .cpuOut(cpuOut), .cpuIn(cpuIn),
        .busyCnt(busyCnt), .seen(seen));

    // --------
    // Shared tasks
    // --------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic busXfer(input logic wr, input logic [7:0] idx,
                           input logic [7:0] wd, output logic [31:0] rd);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= 32'(wd);
        // Only the watchdog ends a wait that never comes
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] t;
        busXfer(1'b1, idx, d, t);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] t;
        busXfer(1'b0, idx, 8'h00, t);
        check(t, 32'(exp));
    endtask

    task automatic cpuStrobe(input logic [3:0] s, input logic [2:0] lv,
                             input int n);
        strobe <= s;
        level <= lv;
        @(posedge clock);
        strobe <= 4'h0;
        repeat (n) @(posedge clock);
    endtask

    task automatic cpuSet(input logic [15:0] pc, input logic [7:0] fl);
        setValue <= {pc, fl};
        setReq <= 1'b1;
        @(posedge clock);
        setReq <= 1'b0;
        @(posedge clock);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic resetCase();
        rdChk(SYS_MODE_IDX, MODE_RESET);
        rdChk(VP_HIGH_IDX, VP_RESET[15:8]);
        rdChk(VP_LOW_IDX, VP_RESET[7:0]);
        rdChk(FLAGS_IDX, FLAGS_RESET);
        wr(8'h10, 8'hFF);
        rdChk(8'h10, 8'h00);
        rdChk(SYS_MODE_IDX, MODE_RESET);
    endtask

    task automatic fastCase(input logic [2:0] lv);
        logic [15:0] pc, vp, pc2;
        logic [7:0] fl;
        pc = {8'h12, 5'h00, lv};
        vp = {5'h10, lv, 8'h3C};
        pc2 = vp + 16'h0010;
        fl = {lv, 5'h11};
        cpuSet(pc, fl);
        // Pointer first, then level and enable together in one mode write
        wr(VP_HIGH_IDX, vp[15:8]);
        wr(VP_LOW_IDX, vp[7:0]);
        wr(SYS_MODE_IDX, {3'h0, lv, 2'b11});
        rdChk(SYS_MODE_IDX, {3'h0, lv, 2'b11});
        cpuStrobe(4'h1, lv, FAST_N + 3);
        check(32'(cpuIn.pc), 32'(vp));
        check(32'(busyCnt), 32'(FAST_N));
        check(32'(seen), 32'h0000_0003);
        rdChk(VP_HIGH_IDX, pc[15:8]);
        rdChk(VP_LOW_IDX, pc[7:0]);
        rdChk(SYS_MODE_IDX, {3'h0, lv, 2'b10});
        // Routine alters the live flags; shadow must win
        cpuSet(pc2, ~fl | FAST_MASK);
        cpuStrobe(4'h2, lv, 3);
        check(32'(cpuIn.pc), 32'(pc));
        check(32'(cpuIn.flags), 32'(fl));
        rdChk(VP_LOW_IDX, pc2[7:0]);
        rdChk(SYS_MODE_IDX, {3'h0, lv, 2'b11});
    endtask

    task automatic normalCase();
        wr(VP_LOW_IDX, 8'h77);
        wr(SYS_MODE_IDX, 8'h0F);
        cpuStrobe(4'h1, 3'h5, NORMAL_N + 3);
        check(32'(busyCnt), 32'(NORMAL_N));
        check(32'(seen), 32'h0000_0007);
        rdChk(VP_LOW_IDX, 8'h77);
        wr(SYS_MODE_IDX, 8'h0D);
        cpuStrobe(4'h1, 3'h3, NORMAL_N + 3);
        check(32'(seen), 32'h0000_0007);
        rdChk(VP_LOW_IDX, 8'h77);
        // Plain return: status bit clear, so no swap
        cpuStrobe(4'h2, 3'h0, 3);
        rdChk(VP_LOW_IDX, 8'h77);
        rdChk(SYS_MODE_IDX, 8'h0D);
    endtask

    task automatic gateCase();
        irqPending <= 1'b1;
        wr(SYS_MODE_IDX, 8'h03);
        check(32'(irqGrant), 32'h0000_0001);
        cpuStrobe(4'h8, 3'h0, 1);
        check(32'(irqGrant), 32'h0000_0000);
        rdChk(SYS_MODE_IDX, 8'h02);
        cpuStrobe(4'h4, 3'h0, 1);
        check(32'(irqGrant), 32'h0000_0001);
        irqPending <= 1'b0;
        @(posedge clock);
        @(posedge clock);
        check(32'(irqGrant), 32'h0000_0000);
    endtask

    // --------
    // Clock, watchdog and main sequence
    // --------
    initial begin
        forever #5 clock = ~clock;
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        errCount++;
        endOfTest();
    end

    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        resetCase();
        for (int i = 0; i < 8; i++) begin
            fastCase(3'(i));
        end
        normalCase();
        gateCase();
        endOfTest();
    end
endmodule
`default_nettype wire
